/* hdl/vradc_pkg.sv */
// vradc_pkg: register map, field layout and reset values of the
// volume ramp, auto-mute and dither configuration bank.
// assumes an 8-bit register port with byte addresses.
package vradc_pkg;

  localparam logic [7:0] EMERG_RAMP_OFS  = 8'h40;
  localparam logic [7:0] AUTO_MUTE_OFS   = 8'h41;
  localparam logic [7:0] PRIM_DITHER_OFS = 8'h43;
  localparam logic [7:0] LEFT_DC_HI_OFS  = 8'h44;

  localparam logic [7:0] EMERG_RAMP_RST  = 8'h10;
  localparam logic [7:0] AUTO_MUTE_RST   = 8'h07;
  localparam logic [7:0] PRIM_DITHER_RST = 8'h00;
  localparam logic [7:0] LEFT_DC_HI_RST  = 8'h00;

  // field positions (low bit of each field)
  localparam int EMERG_IVL_LSB  = 6;
  localparam int EMERG_DEC_LSB  = 4;
  localparam int JOINT_BIT      = 2;
  localparam int EN_POS1_BIT    = 1;
  localparam int EN_POS0_BIT    = 0;
  localparam int L_AC_LSB       = 6;
  localparam int R_AC_LSB       = 4;
  localparam int L_DEM_LSB      = 2;
  localparam int R_DEM_LSB      = 0;
  localparam int DC_AMT_LSB     = 0;

  // ramp interval codes and volume code points (0.5 dB per code)
  localparam logic [1:0] IVL_EVERY_1  = 2'h0;
  localparam logic [1:0] IVL_EVERY_2  = 2'h1;
  localparam logic [1:0] IVL_EVERY_4  = 2'h2;
  localparam logic [1:0] IVL_INSTANT  = 2'h3;
  localparam logic [7:0] VOL_MUTE     = 8'hFF;
  localparam logic [8:0] STEP_4DB     = 9'h008;

endpackage : vradc_pkg

/* hdl/vradc_ramp.sv */
// vradc_ramp: one channel's ramp-down of the volume code toward mute.
// assumes fs_tick is a one-cycle pulse per sample period on clk.
`timescale 1ns/1ns
module vradc_ramp
  import vradc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fs_tick,
  input  wire logic       ramp_req,
  input  wire logic [1:0] interval,
  input  wire logic [1:0] decrement,
  input  wire logic [7:0] vol_set,
  output logic      [7:0] vol_out
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       upd;
  logic [8:0] step;
  logic [8:0] sum;
  logic [7:0] vol_d;

  // update strobe every 1, 2 or 4 sample periods
  assign upd   = fs_tick && ((interval == IVL_EVERY_1) ||
                 (interval == IVL_EVERY_2 && cnt_q[0]) ||
                 (interval == IVL_EVERY_4 && cnt_q == 2'h3));
  assign cnt_d = !ramp_req ? 2'h0 : (fs_tick ? cnt_q + 2'h1 : cnt_q);
  // 4, 2, 1 or 0.5 dB as 8, 4, 2 or 1 codes
  assign step  = STEP_4DB >> decrement;
  assign sum   = {1'b0, vol_out} + step;
  // saturate at mute, never wrap past it
  assign vol_d = !ramp_req ? vol_set :
                 (interval == IVL_INSTANT) ? VOL_MUTE :
                 !upd ? vol_out :
                 (sum >= {1'b0, VOL_MUTE}) ? VOL_MUTE : sum[7:0];

  // counter and volume state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q   <= 2'h0;
      vol_out <= VOL_MUTE;
    end
    else
    begin
      cnt_q   <= cnt_d;
      vol_out <= vol_d;
    end
  end

endmodule : vradc_ramp

/* hdl/vradc_cfg.sv */
// vradc_cfg: configuration bank for emergency volume ramp, auto mute
// and primary dither gains, plus the logic those settings steer.
// assumes register port, fs tick, zero flags and mute requests on CLK.
`timescale 1ns/1ns
module vradc_cfg
  import vradc_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  input  wire logic       FS_TICK,
  input  wire logic       EMERG_REQ,
  input  wire logic       SOFT_MUTE_REQ,
  input  wire logic [1:0] NORM_INTERVAL,
  input  wire logic [1:0] NORM_DECREMENT,
  input  wire logic [7:0] VOL_SET_L,
  input  wire logic [7:0] VOL_SET_R,
  input  wire logic       ZERO_L,
  input  wire logic       ZERO_R,
  output logic      [7:0] VOL_L,
  output logic      [7:0] VOL_R,
  output logic            AUTO_MUTE_L,
  output logic            AUTO_MUTE_R,
  output logic      [1:0] AC_GAIN_L,
  output logic      [1:0] AC_GAIN_R,
  output logic      [1:0] DEM_GAIN_L,
  output logic      [1:0] DEM_GAIN_R,
  output logic      [2:0] DC_DITHER_L
);

  logic       rst_meta_q;
  logic       rst_n;
  logic [7:0] emerg_q;
  logic [7:0] amute_q;
  logic [7:0] dither_q;
  logic [7:0] dchi_q;
  logic       wr_emerg;
  logic       wr_amute;
  logic       wr_dither;
  logic       wr_dchi;
  logic [7:0] rd_mux;
  logic       ramp_req;
  logic [1:0] sel_ivl;
  logic [1:0] sel_dec;
  logic       joint;
  logic       en_left;
  logic       en_right;
  logic       want_l;
  logic       want_r;
  logic       mute_l_d;
  logic       mute_r_d;

  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // address decode
  assign wr_emerg  = REG_WR && (REG_ADDR == EMERG_RAMP_OFS);
  assign wr_amute  = REG_WR && (REG_ADDR == AUTO_MUTE_OFS);
  assign wr_dither = REG_WR && (REG_ADDR == PRIM_DITHER_OFS);
  assign wr_dchi   = REG_WR && (REG_ADDR == LEFT_DC_HI_OFS);
  // unmapped addresses read as zero
  assign rd_mux    = (REG_ADDR == EMERG_RAMP_OFS)  ? emerg_q  :
                     (REG_ADDR == AUTO_MUTE_OFS)   ? amute_q  :
                     (REG_ADDR == PRIM_DITHER_OFS) ? dither_q :
                     (REG_ADDR == LEFT_DC_HI_OFS)  ? dchi_q   : 8'h00;

  // register storage, reserved bits kept as written
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      emerg_q  <= EMERG_RAMP_RST;
      amute_q  <= AUTO_MUTE_RST;
      dither_q <= PRIM_DITHER_RST;
      dchi_q   <= LEFT_DC_HI_RST;
    end
    else
    begin
      if (wr_emerg)
        emerg_q <= REG_WDATA;
      if (wr_amute)
        amute_q <= REG_WDATA;
      if (wr_dither)
        dither_q <= REG_WDATA;
      if (wr_dchi)
        dchi_q <= REG_WDATA;
    end
  end

  // read data one cycle after the read strobe
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= rd_mux;
    end
  end

  // emergency settings take priority over soft mute settings
  assign ramp_req = EMERG_REQ || SOFT_MUTE_REQ;
  assign sel_ivl  = EMERG_REQ ? emerg_q[EMERG_IVL_LSB +: 2] : NORM_INTERVAL;
  assign sel_dec  = EMERG_REQ ? emerg_q[EMERG_DEC_LSB +: 2] : NORM_DECREMENT;

  // per-channel ramp toward mute
  vradc_ramp u_ramp_l (
    .clk       (CLK),
    .rst_n     (rst_n),
    .fs_tick   (FS_TICK),
    .ramp_req  (ramp_req),
    .interval  (sel_ivl),
    .decrement (sel_dec),
    .vol_set   (VOL_SET_L),
    .vol_out   (VOL_L)
  );

  vradc_ramp u_ramp_r (
    .clk       (CLK),
    .rst_n     (rst_n),
    .fs_tick   (FS_TICK),
    .ramp_req  (ramp_req),
    .interval  (sel_ivl),
    .decrement (sel_dec),
    .vol_set   (VOL_SET_R),
    .vol_out   (VOL_R)
  );

  // auto mute: bit 1 governs right, bit 0 governs left
  assign joint    = amute_q[JOINT_BIT];
  assign en_right = amute_q[EN_POS1_BIT];
  assign en_left  = amute_q[EN_POS0_BIT];
  assign want_l   = en_left && ZERO_L;
  assign want_r   = en_right && ZERO_R;
  assign mute_l_d = joint ? (want_l && want_r) : want_l;
  assign mute_r_d = joint ? (want_l && want_r) : want_r;

  // registered auto mute and dither outputs
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      AUTO_MUTE_L <= 1'b0;
      AUTO_MUTE_R <= 1'b0;
      AC_GAIN_L   <= PRIM_DITHER_RST[L_AC_LSB +: 2];
      AC_GAIN_R   <= PRIM_DITHER_RST[R_AC_LSB +: 2];
      DEM_GAIN_L  <= PRIM_DITHER_RST[L_DEM_LSB +: 2];
      DEM_GAIN_R  <= PRIM_DITHER_RST[R_DEM_LSB +: 2];
      DC_DITHER_L <= LEFT_DC_HI_RST[DC_AMT_LSB +: 3];
    end
    else
    begin
      AUTO_MUTE_L <= mute_l_d;
      AUTO_MUTE_R <= mute_r_d;
      AC_GAIN_L   <= dither_q[L_AC_LSB +: 2];
      AC_GAIN_R   <= dither_q[R_AC_LSB +: 2];
      DEM_GAIN_L  <= dither_q[L_DEM_LSB +: 2];
      DEM_GAIN_R  <= dither_q[R_DEM_LSB +: 2];
      DC_DITHER_L <= dchi_q[DC_AMT_LSB +: 3];
    end
  end

  // checks on ramp behaviour
  inst_mute_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:6] == IVL_INSTANT |=> VOL_L == VOL_MUTE && VOL_R == VOL_MUTE)
    else $error("instant emergency mute did not reach mute");

  half_rate_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:6] == IVL_EVERY_2 && FS_TICK && u_ramp_l.cnt_q[0] && VOL_L < 8'hF0
    |=> (VOL_L > $past(VOL_L)) ##1 (EMERG_REQ && !FS_TICK)[*2] |=> VOL_L == $past(VOL_L))
    else $error("two-period emergency ramp updated at wrong time");

  step_size_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:4] == 4'h0 && FS_TICK && VOL_L < 8'hF0
    |=> VOL_L == $past(VOL_L) + 8'h08)
    else $error("4 dB emergency step not applied");

  half_db_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:4] == 4'h3 && FS_TICK && VOL_R < 8'hF0
    |=> VOL_R == $past(VOL_R) + 8'h01)
    else $error("0.5 dB emergency step not applied");

  emerg_prio_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && SOFT_MUTE_REQ |-> sel_ivl == emerg_q[7:6] && sel_dec == emerg_q[5:4])
    else $error("soft mute settings used during emergency ramp");

  mute_floor_a : assert property (@(posedge CLK) disable iff (!rst_n)
    ramp_req && VOL_L == VOL_MUTE ##1 ramp_req |-> VOL_L == VOL_MUTE)
    else $error("volume left mute while ramping");

  // checks on interval timing, the other step sizes and volume tracking without a ramp
  half_hold_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:6] == IVL_EVERY_2 && FS_TICK && !u_ramp_l.cnt_q[0]
    |=> VOL_L == $past(VOL_L))
    else $error("two-period emergency ramp moved on an odd tick");

  quarter_hold_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:6] == IVL_EVERY_4 && FS_TICK && u_ramp_l.cnt_q != 2'h3
    |=> VOL_L == $past(VOL_L))
    else $error("four-period emergency ramp moved early");

  quarter_step_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:6] == IVL_EVERY_4 && FS_TICK && u_ramp_l.cnt_q == 2'h3 &&
    VOL_L < 8'hF0 |=> VOL_L > $past(VOL_L))
    else $error("four-period emergency ramp missed its update");

  two_db_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:4] == 4'h1 && FS_TICK && VOL_L < 8'hF0
    |=> VOL_L == $past(VOL_L) + 8'h04)
    else $error("2 dB emergency step not applied");

  one_db_a : assert property (@(posedge CLK) disable iff (!rst_n)
    EMERG_REQ && emerg_q[7:4] == 4'h2 && FS_TICK && VOL_R < 8'hF0
    |=> VOL_R == $past(VOL_R) + 8'h02)
    else $error("1 dB emergency step not applied");

  vol_track_a : assert property (@(posedge CLK) disable iff (!rst_n)
    !ramp_req |=> VOL_L == $past(VOL_SET_L) && VOL_R == $past(VOL_SET_R))
    else $error("volume did not follow its setting without a ramp");

  // checks on auto mute
  indep_mute_a : assert property (@(posedge CLK) disable iff (!rst_n)
    !joint && en_left && ZERO_L && !ZERO_R |=> AUTO_MUTE_L && !AUTO_MUTE_R)
    else $error("independent auto mute wrong");

  joint_wait_a : assert property (@(posedge CLK) disable iff (!rst_n)
    joint && ZERO_L && !ZERO_R |=> !AUTO_MUTE_L)
    else $error("joint auto mute fired with one channel nonzero");

  zero_cause_a : assert property (@(posedge CLK) disable iff (!rst_n)
    AUTO_MUTE_R |-> $past(ZERO_R))
    else $error("auto mute without zero detection");

  reset_vals_a : assert property (@(posedge CLK)
    $rose(rst_n) |-> amute_q[2:0] == 3'h7)
    else $error("auto mute bits not set after reset");

  pos1_off_a : assert property (@(posedge CLK) disable iff (!rst_n)
    !en_right |=> !AUTO_MUTE_R)
    else $error("right channel muted while disabled");

  pos0_off_a : assert property (@(posedge CLK) disable iff (!rst_n)
    !en_left |=> !AUTO_MUTE_L)
    else $error("left channel muted while disabled");

  joint_block_a : assert property (@(posedge CLK) disable iff (!rst_n)
    joint && !en_right |=> !AUTO_MUTE_L)
    else $error("joint mode muted left with right disabled");

  joint_both_a : assert property (@(posedge CLK) disable iff (!rst_n)
    joint && en_left && en_right && ZERO_L && ZERO_R |=> AUTO_MUTE_L && AUTO_MUTE_R)
    else $error("joint auto mute missed with both channels zero");

  right_block_a : assert property (@(posedge CLK) disable iff (!rst_n)
    joint && !en_left |=> !AUTO_MUTE_R)
    else $error("joint mode muted right with left disabled");

  // checks on dither fields
  ac_gain_a : assert property (@(posedge CLK) disable iff (!rst_n)
    wr_dither |=> ##1 AC_GAIN_L == $past(REG_WDATA[7:6], 2) &&
    AC_GAIN_R == $past(REG_WDATA[5:4], 2))
    else $error("AC dither gain not taken from write");

  dem_gain_a : assert property (@(posedge CLK) disable iff (!rst_n)
    wr_dither |=> ##1 DEM_GAIN_L == $past(REG_WDATA[3:2], 2) &&
    DEM_GAIN_R == $past(REG_WDATA[1:0], 2))
    else $error("DEM dither gain not taken from write");

  dc_copy_a : assert property (@(posedge CLK) disable iff (!rst_n)
    wr_dchi |=> ##1 DC_DITHER_L == $past(REG_WDATA[2:0], 2))
    else $error("DC dither amount not taken from write");

  // checks on the register port
  rd_valid_a : assert property (@(posedge CLK) disable iff (!rst_n)
    REG_RD |=> REG_RVALID)
    else $error("read strobe gave no valid pulse");

  rd_zero_a : assert property (@(posedge CLK) disable iff (!rst_n)
    REG_RD && REG_ADDR != EMERG_RAMP_OFS && REG_ADDR != AUTO_MUTE_OFS &&
    REG_ADDR != PRIM_DITHER_OFS && REG_ADDR != LEFT_DC_HI_OFS |=> REG_RDATA == 8'h00)
    else $error("unmapped read returned nonzero data");

endmodule : vradc_cfg

/* verif/volume_ramp_automute_dither_cfg_tb.sv */
// volume_ramp_automute_dither_cfg_tb: self-checking bench for vradc_cfg.
// assumes vradc_pkg and vradc_cfg are compiled before this file.
`timescale 1ns/1ns
module volume_ramp_automute_dither_cfg_tb;
  import vradc_pkg::*;

  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} vradc_row_s;

  logic       CLK, RST_N, REG_WR, REG_RD, REG_RVALID, FS_TICK;
  logic       EMERG_REQ, SOFT_MUTE_REQ, ZERO_L, ZERO_R, AUTO_MUTE_L, AUTO_MUTE_R;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, VOL_SET_L, VOL_SET_R, VOL_L, VOL_R;
  logic [1:0] NORM_INTERVAL, NORM_DECREMENT, AC_GAIN_L, AC_GAIN_R, DEM_GAIN_L, DEM_GAIN_R;
  logic [2:0] DC_DITHER_L;
  logic [7:0] q;
  logic [7:0] exp_l;
  int         n_errors;
  int         checks;

  // write, read back: mapped places store all 8 bits, unmapped read zero
  vradc_row_s rows [6] = '{'{8'h40, 8'hA5, 8'hA5}, '{8'h41, 8'hF8, 8'hF8},
                           '{8'h43, 8'h55, 8'h55}, '{8'h44, 8'hFF, 8'hFF},
                           '{8'h42, 8'h3C, 8'h00}, '{8'h45, 8'h99, 8'h00}};
  logic [7:0] rst_a [4] = '{EMERG_RAMP_OFS, AUTO_MUTE_OFS, PRIM_DITHER_OFS, LEFT_DC_HI_OFS};
  logic [7:0] rst_e [4] = '{8'h10, 8'h07, 8'h00, 8'h00};

  vradc_cfg DUT (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .FS_TICK(FS_TICK), .EMERG_REQ(EMERG_REQ), .SOFT_MUTE_REQ(SOFT_MUTE_REQ),
    .NORM_INTERVAL(NORM_INTERVAL), .NORM_DECREMENT(NORM_DECREMENT),
    .VOL_SET_L(VOL_SET_L), .VOL_SET_R(VOL_SET_R), .ZERO_L(ZERO_L), .ZERO_R(ZERO_R),
    .VOL_L(VOL_L), .VOL_R(VOL_R), .AUTO_MUTE_L(AUTO_MUTE_L), .AUTO_MUTE_R(AUTO_MUTE_R),
    .AC_GAIN_L(AC_GAIN_L), .AC_GAIN_R(AC_GAIN_R), .DEM_GAIN_L(DEM_GAIN_L),
    .DEM_GAIN_R(DEM_GAIN_R), .DC_DITHER_L(DC_DITHER_L));

  // 250 MHz clock
  initial CLK = 1'b0;
  always #2 CLK = ~CLK;

  task automatic wrap_up();
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR    <= 1'b0;
  endtask : wr

  // read strobe, then bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD   <= 1'b0;
    #1;
    while (REG_RVALID !== 1'b1 && k < 4)
    begin
      @(posedge CLK);
      #1;
      k++;
    end
    if (k == 4)
    begin
      n_errors++;
      $display("unexpected at %0t: no read valid", $time);
      wrap_up();
    end
    else
      d = REG_RDATA;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : idle

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge CLK);
      FS_TICK <= 1'b1;
      @(posedge CLK);
      FS_TICK <= 1'b0;
      repeat (2) @(posedge CLK);
    end
    #1;
  endtask : ticks

  // hang guard
  initial
  begin
    repeat (50000) @(posedge CLK);
    n_errors++;
    $display("unexpected at %0t: run timed out", $time);
    wrap_up();
  end

  // main sequence
  initial
  begin
    {RST_N, REG_WR, REG_RD, FS_TICK, EMERG_REQ, SOFT_MUTE_REQ, ZERO_L, ZERO_R} = '0;
    {REG_ADDR, REG_WDATA, NORM_INTERVAL, NORM_DECREMENT} = '0;
    VOL_SET_L = 8'h30;
    VOL_SET_R = 8'h20;
    n_errors = 0;
    checks = 0;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    foreach (rst_a[i])
    begin
      rd(rst_a[i], q);
      chk(q, rst_e[i], "reset value");
    end
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      chk(q, rows[i].e, "read back");
    end
    // gain and dc dither fields reach their outputs
    wr(8'h43, 8'h55);
    idle(3);
    chk({AC_GAIN_L, AC_GAIN_R, DEM_GAIN_L, DEM_GAIN_R}, 8'h55, "gains 01");
    wr(8'h43, 8'h00);
    wr(8'h44, 8'hFD);
    idle(3);
    chk({AC_GAIN_L, AC_GAIN_R, DEM_GAIN_L, DEM_GAIN_R}, 8'h00, "gains 00");
    chk({5'h00, DC_DITHER_L}, 8'h05, "dc dither");
    // auto mute over every control setting and zero pattern
    for (int r = 0; r < 8; r++)
      for (int z = 0; z < 4; z++)
      begin
        wr(8'h41, 8'(r));
        @(posedge CLK);
        ZERO_L <= z[0];
        ZERO_R <= z[1];
        idle(3);
        exp_l = {6'h00, r[1] & z[1], r[0] & z[0]};
        if (r[2])
          exp_l = {6'h00, {2{r[1] & z[1] & r[0] & z[0]}}};
        chk({6'h00, AUTO_MUTE_R, AUTO_MUTE_L}, exp_l, "auto mute");
      end
    // emergency ramp: every stepped interval (1, 2 or 4 periods) and step, 8 ticks from the start
    for (int iv = 0; iv < 3; iv++)
      for (int dc = 0; dc < 4; dc++)
      begin
        wr(8'h40, {iv[1:0], dc[1:0], 4'h0});
        @(posedge CLK);
        EMERG_REQ <= 1'b1;
        ticks(8);
        chk(VOL_L, 8'(8'h30 + (64 >> (iv + dc))), "ramp left");
        chk(VOL_R, 8'(8'h20 + (64 >> (iv + dc))), "ramp right");
        @(posedge CLK);
        EMERG_REQ <= 1'b0;
        idle(2);
        chk(VOL_L, 8'h30, "ramp release");
      end
    // instant mute
    wr(8'h40, 8'hC0);
    @(posedge CLK);
    EMERG_REQ <= 1'b1;
    idle(2);
    chk(VOL_L, 8'hFF, "instant mute");
    // ramp stops at mute
    wr(8'h40, 8'h00);
    @(posedge CLK);
    EMERG_REQ <= 1'b0;
    VOL_SET_L <= 8'hF8;
    idle(2);
    @(posedge CLK);
    EMERG_REQ <= 1'b1;
    ticks(3);
    chk(VOL_L, 8'hFF, "saturate");
    @(posedge CLK);
    EMERG_REQ <= 1'b0;
    VOL_SET_L <= 8'h30;
    // soft mute uses normal step, emergency overrides it
    wr(8'h40, 8'h30);
    @(posedge CLK);
    SOFT_MUTE_REQ <= 1'b1;
    NORM_INTERVAL <= 2'h1;
    ticks(2);
    chk(VOL_L, 8'h38, "soft ramp");
    @(posedge CLK);
    SOFT_MUTE_REQ <= 1'b0;
    idle(2);
    @(posedge CLK);
    SOFT_MUTE_REQ <= 1'b1;
    EMERG_REQ <= 1'b1;
    ticks(2);
    chk(VOL_L, 8'h32, "emergency priority");
    // reset in mid-run restores defaults
    wr(8'h41, 8'h00);
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    idle(3);
    rd(8'h41, q);
    chk(q, 8'h07, "second reset");
    wrap_up();
  end

endmodule : volume_ramp_automute_dither_cfg_tb
